// ===== bench/shared_pin_function_mux_tb.sv
// Self-checking bench for the shared pin function mux
module shared_pin_function_mux_tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [31:0] M = 32'h3fff_ffcf;
    logic hclk, hresetn, por_n, hsel, hwrite, hreadyout, hresp, dbg_drive_val, dbg_drive_en;
    logic hold_low, switch_low, lvl5, pin4, pin5, lv, dbg_rx_level, dbg_role, dbg_bit_tick;
    logic active_bg_mode, force_reset_req, pin_reset_req, irq_level, timer_clk_in;
    logic [31:0] haddr, hwdata, hrdata, rd, r1, r2, r3, r4;
    logic [1:0]  htrans, e;
    logic [2:0]  hsize = 3'h2;
    logic [spm_pkg::NPINS-1:0] pad_rnd, pad_o, pad_oe_n, pad_pullup, pad_drive_hi, pad_slew_en;
    int     miscompares, comparisons, cycles, n;
    integer seed;

    spm_pin_mux dut_u (.hclk(hclk), .hresetn(hresetn), .por_n(por_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .pad_i({pad_rnd[29:6], pin5, pin4, pad_rnd[3:0]}), .pad_o(pad_o), .pad_oe_n(pad_oe_n),
        .pad_pullup(pad_pullup), .pad_drive_hi(pad_drive_hi), .pad_slew_en(pad_slew_en),
        .dbg_drive_val(dbg_drive_val), .dbg_drive_en(dbg_drive_en), .dbg_rx_level(dbg_rx_level),
        .dbg_role(dbg_role), .dbg_bit_tick(dbg_bit_tick), .active_bg_mode(active_bg_mode),
        .force_reset_req(force_reset_req), .pin_reset_req(pin_reset_req), .irq_level(irq_level),
        .timer_clk_in(timer_clk_in));
    spm_dbg_pod pod_u (.hclk(hclk), .hold_low(hold_low), .switch_low(switch_low), .tb_lvl5(lvl5),
        .dev_o4(pad_o[4]), .dev_oe_n4(pad_oe_n[4]), .pu4(pad_pullup[4]), .pu5(pad_pullup[5]),
        .pin4(pin4), .pin5(pin5));

    // Bus clock, 100 ns period
    always #50 hclk = ~hclk;

    // Cut a hang short
    always @(posedge hclk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            $display("mismatch at %0t: timeout", $time);
            tally_and_finish();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic tally_and_finish();
        if (miscompares == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // One single word transfer: address phase, then data phase
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rv);
        hsel <= 1'b1;
        haddr <= {24'h00_0000, a};
        htrans <= 2'h2;
        hwrite <= wr;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rv = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] dummy;
        bus(1'b1, a, d, dummy);
    endtask

    // Reset of either kind, pod optionally holding the mode pin low
    task automatic do_reset(input logic por, input logic hold);
        hresetn <= 1'b0;
        por_n <= ~por;
        hold_low <= hold;
        repeat (16) @(posedge hclk);
        chk(32'(pad_oe_n[4]), 32'h1);
        hresetn <= 1'b1;
        por_n <= 1'b1;
        repeat (6) @(posedge hclk);
        hold_low <= 1'b0;
        @(posedge hclk);
    endtask

    // Owner of the shared pin from {timer clock, interrupt, reset} enables
    function automatic logic [1:0] exp_fn(input logic [2:0] k);
        return k[0] ? 2'h3 : k[2] ? 2'h2 : k[1] ? 2'h1 : 2'h0;
    endfunction

    // Main sequence
    initial begin
        hclk = 1'b0;
        {hresetn, por_n, hsel, hwrite, dbg_drive_val, dbg_drive_en, hold_low, switch_low} = 8'h00;
        lvl5 = 1'b1;
        haddr = 32'h0;
        hwdata = 32'h0;
        htrans = 2'h0;
        {miscompares, comparisons, cycles} = {32'h0, 32'h0, 32'h0};
        seed = 32'had85;
        pad_rnd = 30'($random(seed));
        do_reset(1'b1, 1'b0);
        bus(1'b0, spm_pkg::ADDR_OPT, 32'h0, rd);
        chk(rd, 32'h1);
        chk(32'(pad_oe_n), 32'h3fff_ffff);
        chk(32'(pad_pullup) & M, 32'h0);
        chk({30'h0, active_bg_mode, dbg_role}, 32'h1);
        n = 0;
        while (dbg_bit_tick !== 1'b1 && n < 40) begin
            @(posedge hclk);
            n++;
        end
        @(posedge hclk);
        n = 1;
        while (dbg_bit_tick !== 1'b1 && n < 40) begin
            @(posedge hclk);
            n++;
        end
        chk(32'(n), 32'h10);
        dbg_drive_en <= 1'b1;
        dbg_drive_val <= 1'b1;
        repeat (2) @(posedge hclk);
        chk({30'h0, pad_oe_n[4], pad_o[4]}, 32'h1);
        dbg_drive_en <= 1'b0;
        dbg_drive_val <= 1'b0;
        // Every mix of the shared pin's functions
        for (int k = 0; k < 8; k++) begin
            wr(spm_pkg::ADDR_OPT, 32'h1);
            lvl5 <= 1'($random(seed));
            switch_low <= 1'($random(seed));
            wr(spm_pkg::ADDR_OPT, {28'h0, 3'(k), 1'b1});
            repeat (5) @(posedge hclk);
            e = exp_fn(3'(k));
            lv = switch_low ? 1'b0 : (e == 2'h3 ? 1'b1 : lvl5);
            bus(1'b0, spm_pkg::ADDR_STAT, 32'h0, rd);
            chk({29'h0, rd[3:1]}, {29'h0, lv, e});
            chk(32'(irq_level), 32'(e == 2'h1 ? lv : 1'b1));
            chk(32'(timer_clk_in), 32'(e == 2'h2 ? lv : 1'b0));
            chk(32'(pin_reset_req), 32'(e == 2'h3 && !lv));
            chk({30'h0, pad_oe_n[5], pad_pullup[5]}, {30'h0, 1'b1, e == 2'h3});
        end
        switch_low <= 1'b0;
        wr(spm_pkg::ADDR_OPT, 32'h2);
        do_reset(1'b0, 1'b0);
        bus(1'b0, spm_pkg::ADDR_OPT, 32'h0, rd);
        chk(rd, 32'h3);
        do_reset(1'b1, 1'b0);
        bus(1'b0, spm_pkg::ADDR_OPT, 32'h0, rd);
        chk(rd, 32'h1);
        // Port line registers with random contents
        wr(spm_pkg::ADDR_OPT, 32'h0);
        for (int i = 0; i < 4; i++) begin
            {r1, r2, r3, r4} = {$random(seed), $random(seed), $random(seed), $random(seed)};
            wr(spm_pkg::ADDR_DIR, r1);
            wr(spm_pkg::ADDR_PULL, r2);
            wr(spm_pkg::ADDR_DRV, r3);
            wr(spm_pkg::ADDR_SLEW, r4);
            wr(spm_pkg::ADDR_DOUT, r2);
            pad_rnd <= 30'($random(seed));
            repeat (4) @(posedge hclk);
            chk(32'(pad_oe_n) & M, ~r1 & M);
            chk(32'(pad_pullup) & M, r2 & ~r1 & M);
            chk(32'(pad_drive_hi) & M, r3 & r1 & M);
            chk(32'(pad_slew_en) & M, r4 & r1 & M);
            chk({27'h0, pad_oe_n[5:4], pad_o[4], dbg_role, dbg_rx_level}, {27'h0, 2'h2, r2[4], 1'b0, r2[4]});
            bus(1'b0, spm_pkg::ADDR_DIN, 32'h0, rd);
            chk(rd & M, 32'(pad_rnd) & M);
            bus(1'b0, spm_pkg::ADDR_DIR, 32'h0, rd);
            chk(rd & M, r1 & M);
        end
        bus(1'b0, 8'h40, 32'h0, rd);
        chk(rd, 32'h0);
        chk(32'(hresp), 32'h0);
        // Mode pin held low at power-on, forced and plain resets
        for (int m = 0; m < 3; m++) begin
            if (m == 1) begin
                wr(spm_pkg::ADDR_FRC, 32'h1);
                n = 0;
                while (force_reset_req !== 1'b1 && n < 8) begin
                    @(posedge hclk);
                    n++;
                end
                chk(32'(n < 8), 32'h1);
            end
            do_reset(m == 0, 1'b1);
            chk(32'(active_bg_mode), 32'(m < 2));
        end
        tally_and_finish();
    end
endmodule

// ===== bench/spm_dbg_pod.sv
// Debug pod and board reset switch at the two shared pins
module spm_dbg_pod (
    input  wire logic hclk,
    input  wire logic hold_low,
    input  wire logic switch_low,
    input  wire logic tb_lvl5,
    input  wire logic dev_o4,
    input  wire logic dev_oe_n4,
    input  wire logic pu4,
    input  wire logic pu5,
    output logic      pin4,
    output logic      pin5
);
    timeunit 1ns;
    timeprecision 1ns;
    logic last4_ff;
    // A wire nobody holds wanders, so it shows the inverse of its last level
    always_ff @(posedge hclk) begin
        last4_ff <= pin4;
    end
    // Pod only pulls low; once released the device or the pullup decides
    assign pin4 = !dev_oe_n4 ? dev_o4 : hold_low ? 1'b0 : pu4 ? 1'b1 : ~last4_ff;
    // Switch to ground wins; otherwise the pullup holds the line high, or without the pullup the bench level drives it
    assign pin5 = switch_low ? 1'b0 : pu5 ? 1'b1 : tb_lvl5;
endmodule

// ===== rtl/spm_pin_mux.sv
// Pin function selection, pad controls and mode select sampling

// Contract
// - After power-on, the shared pin's reset function is off; pin acts as port.
// - Only power-on reset restores the reset-function enable; other resets keep it.
// - As reset input the shared pin gets pullup, is input only, never driven.
// - In interrupt role the pin level feeds the interrupt and branch test.
// - In timer-clock role the pin clocks the timer units and modulo timer.
// - As plain port line five the pin is input only.
// - During power-on or forced reset the debug pin is a mode select input.
// - On reset release the debug pin takes its debug communication role.
// - Every reset sets the debug pin enable; software clears it for port line four.
// - Mode pin high at reset release gives normal run mode.
// - Mode pin held low at power-on or forced reset gives background mode.
// - Each debug link bit spans 16 debug controller clocks.
// - Debug controller clock may run up to the bus clock rate.
// - Debug pin is pseudo open-drain with brief driven-high speedup pulses.
// - Thirty port lines; line four output only, line five input only.
// - Outputs get drive strength and slew control; inputs get pullup enable.
// - After reset every port pin is a high-impedance input, pullup off; line four keeps its pullup on, as does line five with reset function on.
// - Highest enabled function owns a pin: port, interrupt, timer clock, reset.
// - Writing one to the force bit requests a debug forced reset.
module spm_pin_mux (
    input  wire logic                      hclk,
    input  wire logic                      hresetn,
    input  wire logic                      por_n,
    input  wire logic                      hsel,
    input  wire logic [31:0]               haddr,
    input  wire logic [1:0]                htrans,
    input  wire logic                      hwrite,
    input  wire logic [2:0]                hsize,
    input  wire logic [31:0]               hwdata,
    input  wire logic                      hready,
    output logic      [31:0]               hrdata,
    output logic                           hreadyout,
    output logic                           hresp,
    input  wire logic [spm_pkg::NPINS-1:0] pad_i,
    output logic      [spm_pkg::NPINS-1:0] pad_o,
    output logic      [spm_pkg::NPINS-1:0] pad_oe_n,
    output logic      [spm_pkg::NPINS-1:0] pad_pullup,
    output logic      [spm_pkg::NPINS-1:0] pad_drive_hi,
    output logic      [spm_pkg::NPINS-1:0] pad_slew_en,
    input  wire logic                      dbg_drive_val,
    input  wire logic                      dbg_drive_en,
    output logic                           dbg_rx_level,
    output logic                           dbg_role,
    output logic                           dbg_bit_tick,
    output logic                           active_bg_mode,
    output logic                           force_reset_req,
    output logic                           pin_reset_req,
    output logic                           irq_level,
    output logic                           timer_clk_in
);
    localparam int DP = spm_pkg::DBG_PIN;
    localparam int SP = spm_pkg::SHR_PIN;

    logic [spm_pkg::NPINS-1:0] pin_sync;
    logic                      dbg_en_ff;
    logic                      rst_en_ff;
    logic                      irq_en_ff;
    logic                      external_timer_clock_in_en_ff;
    logic                      cause_por_ff;
    logic                      cause_frc_ff;
    logic [spm_pkg::NPINS-1:0] dir_ff;
    logic [spm_pkg::NPINS-1:0] dout_ff;
    logic [spm_pkg::NPINS-1:0] pull_ff;
    logic [spm_pkg::NPINS-1:0] drv_ff;
    logic [spm_pkg::NPINS-1:0] slew_ff;
    logic                      wr_pend_ff;
    logic [7:0]                wr_addr_ff;
    logic [31:0]               rdata_ff;
    logic                      released_ff;
    logic [1:0]                dly_ff;
    logic                      bgnd_ff;
    logic [3:0]                bit_cnt_ff;
    logic                      frc_ff;
    logic                      ext_rst_ff;
    logic                      irq_ff;
    logic                      external_timer_clock_in_ff;
    spm_pkg::spm_state_type    st_ff;
    spm_pkg::spm_state_type    nxt_st;
    spm_pkg::spm_func_type     sel;
    logic                      req;
    logic                      stall;
    logic                      wr_now;
    logic [31:0]               rd_mux;

    // Pad inputs cross into the bus clock domain
    spm_sync #(.W(spm_pkg::NPINS), .RST(spm_pkg::SYNC_RST)) u_sync (
        .clk   (hclk),
        .rst_n (hresetn),
        .d     (pad_i),
        .q     (pin_sync)
    );

    // Bus request decode; a read right after a write waits one cycle
    assign req       = hsel && hready && htrans[1];
    assign stall     = wr_pend_ff && hsel && htrans[1] && !hwrite;
    assign hreadyout = !stall;
    assign hresp     = 1'b0;
    assign hrdata    = rdata_ff;
    assign wr_now    = wr_pend_ff;

    // Address phase capture for writes
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_ff <= 1'b0;
            wr_addr_ff <= 8'h00;
        end else if (req && hwrite && !stall) begin
            wr_pend_ff <= 1'b1;
            wr_addr_ff <= haddr[7:0];
        end else begin
            wr_pend_ff <= 1'b0;
        end
    end

    // Read data mux, unmapped offsets read zero
    always_comb begin
        rd_mux = 32'h0000_0000;
        case (haddr[7:0])
            spm_pkg::ADDR_OPT: begin
                rd_mux[spm_pkg::OPT_DBG_EN]  = dbg_en_ff;
                rd_mux[spm_pkg::OPT_RST_EN]  = rst_en_ff;
                rd_mux[spm_pkg::OPT_IRQ_EN]  = irq_en_ff;
                rd_mux[spm_pkg::OPT_EXTERNAL_TIMER_CLOCK_IN_EN] = external_timer_clock_in_en_ff;
            end
            spm_pkg::ADDR_STAT: begin
                rd_mux[0]   = bgnd_ff;
                rd_mux[2:1] = sel;
                rd_mux[3]   = pin_sync[SP];
                rd_mux[4]   = dbg_role;
            end
            spm_pkg::ADDR_DIR:  rd_mux[spm_pkg::NPINS-1:0] = dir_ff;
            spm_pkg::ADDR_DOUT: rd_mux[spm_pkg::NPINS-1:0] = dout_ff;
            spm_pkg::ADDR_DIN:  rd_mux[spm_pkg::NPINS-1:0] = pin_sync;
            spm_pkg::ADDR_PULL: rd_mux[spm_pkg::NPINS-1:0] = pull_ff;
            spm_pkg::ADDR_DRV:  rd_mux[spm_pkg::NPINS-1:0] = drv_ff;
            spm_pkg::ADDR_SLEW: rd_mux[spm_pkg::NPINS-1:0] = slew_ff;
            default:            rd_mux = 32'h0000_0000;
        endcase
    end

    // Read data is registered at the address phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rdata_ff <= 32'h0000_0000;
        end else if (req && !hwrite && !stall) begin
            rdata_ff <= rd_mux;
        end
    end

    // Function enables reset by every reset
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dbg_en_ff  <= spm_pkg::DBG_EN_RST;
            irq_en_ff  <= spm_pkg::IRQ_EN_RST;
            external_timer_clock_in_en_ff <= spm_pkg::EXTERNAL_TIMER_CLOCK_IN_EN_RST;
        end else if (wr_now && wr_addr_ff == spm_pkg::ADDR_OPT) begin
            dbg_en_ff  <= hwdata[spm_pkg::OPT_DBG_EN];
            irq_en_ff  <= hwdata[spm_pkg::OPT_IRQ_EN];
            external_timer_clock_in_en_ff <= hwdata[spm_pkg::OPT_EXTERNAL_TIMER_CLOCK_IN_EN];
        end
    end

    // Reset-function enable survives all but power-on reset
    always_ff @(posedge hclk or negedge por_n) begin
        if (!por_n) begin
            rst_en_ff <= spm_pkg::RST_EN_RST;
        end else if (hresetn && wr_now && wr_addr_ff == spm_pkg::ADDR_OPT) begin
            rst_en_ff <= hwdata[spm_pkg::OPT_RST_EN];
        end
    end

    // Reset causes that make the mode pin count
    always_ff @(posedge hclk or negedge por_n) begin
        if (!por_n) begin
            cause_por_ff <= 1'b1;
            cause_frc_ff <= 1'b0;
        end else if (hresetn && st_ff == spm_pkg::ST_SAMPLE) begin
            cause_por_ff <= 1'b0;
            cause_frc_ff <= frc_ff;
        end else if (hresetn && frc_ff) begin
            cause_frc_ff <= 1'b1;
        end
    end

    // Force reset request pulse
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            frc_ff <= 1'b0;
        end else begin
            frc_ff <= wr_now && wr_addr_ff == spm_pkg::ADDR_FRC && hwdata[spm_pkg::FRC_BIT];
        end
    end
    assign force_reset_req = frc_ff;

    // Port configuration registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dir_ff  <= spm_pkg::PORT_RST;
            dout_ff <= spm_pkg::PORT_RST;
            pull_ff <= spm_pkg::PORT_RST;
            drv_ff  <= spm_pkg::PORT_RST;
            slew_ff <= spm_pkg::PORT_RST;
        end else if (wr_now) begin
            case (wr_addr_ff)
                spm_pkg::ADDR_DIR:  dir_ff  <= hwdata[spm_pkg::NPINS-1:0];
                spm_pkg::ADDR_DOUT: dout_ff <= hwdata[spm_pkg::NPINS-1:0];
                spm_pkg::ADDR_PULL: pull_ff <= hwdata[spm_pkg::NPINS-1:0];
                spm_pkg::ADDR_DRV:  drv_ff  <= hwdata[spm_pkg::NPINS-1:0];
                spm_pkg::ADDR_SLEW: slew_ff <= hwdata[spm_pkg::NPINS-1:0];
                default:            dir_ff  <= dir_ff;
            endcase
        end
    end

    // Priority owner of the shared pin
    always_comb begin
        if (rst_en_ff) begin
            sel = spm_pkg::FN_RESET;
        end else if (external_timer_clock_in_en_ff) begin
            sel = spm_pkg::FN_EXTERNAL_TIMER_CLOCK_IN;
        end else if (irq_en_ff) begin
            sel = spm_pkg::FN_IRQ;
        end else begin
            sel = spm_pkg::FN_PORT;
        end
    end

    // Shared pin routed to the owning function
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ext_rst_ff <= 1'b0;
            irq_ff     <= 1'b1;
            external_timer_clock_in_ff    <= 1'b0;
        end else begin
            ext_rst_ff <= sel == spm_pkg::FN_RESET && !pin_sync[SP];
            irq_ff     <= sel == spm_pkg::FN_IRQ ? pin_sync[SP] : 1'b1;
            external_timer_clock_in_ff    <= sel == spm_pkg::FN_EXTERNAL_TIMER_CLOCK_IN && pin_sync[SP];
        end
    end
    assign pin_reset_req = ext_rst_ff;
    assign irq_level     = irq_ff;
    assign timer_clk_in  = external_timer_clock_in_ff;

    // Reset release marker
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            released_ff <= 1'b0;
        end else begin
            released_ff <= 1'b1;
        end
    end

    // Mode sampling sequence
    always_comb begin
        case (st_ff)
            spm_pkg::ST_WAIT:   nxt_st = dly_ff == spm_pkg::SAMPLE_DLY ? spm_pkg::ST_SAMPLE : spm_pkg::ST_WAIT;
            spm_pkg::ST_SAMPLE: nxt_st = spm_pkg::ST_DONE;
            spm_pkg::ST_DONE:   nxt_st = spm_pkg::ST_DONE;
            default:            nxt_st = spm_pkg::ST_DONE;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_ff  <= spm_pkg::ST_WAIT;
            dly_ff <= 2'h0;
        end else begin
            st_ff  <= nxt_st;
            dly_ff <= st_ff == spm_pkg::ST_WAIT ? dly_ff + 2'h1 : dly_ff;
        end
    end

    // Mode latched from the pin only after power-on or forced reset
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bgnd_ff <= 1'b0;
        end else if (st_ff == spm_pkg::ST_SAMPLE && (cause_por_ff || cause_frc_ff)) begin
            bgnd_ff <= !pin_sync[DP];
        end
    end
    assign active_bg_mode = bgnd_ff;

    // Debug pin role follows release and the enable
    assign dbg_role     = released_ff && dbg_en_ff;
    assign dbg_rx_level = pin_sync[DP];

    // Bit timer, debug clock taken at bus rate
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bit_cnt_ff <= 4'h0;
        end else if (!dbg_role) begin
            bit_cnt_ff <= 4'h0;
        end else begin
            bit_cnt_ff <= bit_cnt_ff + 4'h1;
        end
    end
    assign dbg_bit_tick = dbg_role && bit_cnt_ff == spm_pkg::BIT_LAST;

    // Pad drive: line four output only, line five never driven
    always_comb begin
        pad_o    = dout_ff;
        pad_oe_n = ~dir_ff;
        pad_oe_n[SP] = 1'b1;
        if (!released_ff) begin
            pad_oe_n[DP] = 1'b1;
        end else if (dbg_en_ff) begin
            pad_o[DP]    = dbg_drive_val;
            pad_oe_n[DP] = !dbg_drive_en;
        end else begin
            pad_oe_n[DP] = 1'b0;
        end
    end

    // Pullups and output pad options
    always_comb begin
        pad_pullup     = pull_ff & ~dir_ff;
        pad_pullup[SP] = pull_ff[SP] || sel == spm_pkg::FN_RESET;
        pad_pullup[DP] = dbg_en_ff || !released_ff;
        pad_drive_hi   = drv_ff & dir_ff;
        pad_slew_en    = slew_ff & dir_ff;
    end

    // Checks
    keeps_rst_en_a: assert property (@(posedge hclk)
        (por_n && $past(por_n) && !hresetn && !$past(hresetn)) |-> $stable(rst_en_ff))
        else $error("reset enable changed in non power-on reset");
    por_port_a: assert property (@(posedge hclk) disable iff (!hresetn)
        ($past(!por_n) && por_n) |-> sel != spm_pkg::FN_RESET)
        else $error("reset function on after power-on");
    shr_undriven_a: assert property (@(posedge hclk) disable iff (!hresetn)
        pad_oe_n[SP] && (sel != spm_pkg::FN_RESET || pad_pullup[SP]))
        else $error("shared pin driven or unpulled");
    irq_route_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (sel == spm_pkg::FN_IRQ && $stable(sel)) |=> irq_level == $past(pin_sync[SP], 1))
        else $error("interrupt level not routed");
    external_timer_clock_in_route_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (sel != spm_pkg::FN_EXTERNAL_TIMER_CLOCK_IN) |=> !timer_clk_in)
        else $error("timer clock leaks");
    prio_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (rst_en_ff |-> sel == spm_pkg::FN_RESET) and (external_timer_clock_in_en_ff && !rst_en_ff |-> sel == spm_pkg::FN_EXTERNAL_TIMER_CLOCK_IN))
        else $error("priority wrong");
    dbg_en_rst_a: assert property (@(posedge hclk) disable iff (!hresetn)
        $rose(released_ff) |-> dbg_en_ff && dbg_role)
        else $error("debug enable not set after reset");
    mode_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (st_ff == spm_pkg::ST_SAMPLE && (cause_por_ff || cause_frc_ff)) |=> bgnd_ff == !$past(pin_sync[DP]))
        else $error("mode sample wrong");
    bit_time_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (dbg_bit_tick && dbg_role) |=> !dbg_bit_tick [*8] ##1 !dbg_bit_tick [*7])
        else $error("bit time not 16 clocks");
    force_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (wr_now && wr_addr_ff == spm_pkg::ADDR_FRC && hwdata[0]) |=> force_reset_req ##1 !force_reset_req)
        else $error("force request not pulsed");
    opt_wr_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (wr_now && wr_addr_ff == spm_pkg::ADDR_OPT) |=> dbg_en_ff == $past(hwdata[0]))
        else $error("option write late");
    port_rst_a: assert property (@(posedge hclk) disable iff (!hresetn)
        $rose(released_ff) |-> dir_ff == spm_pkg::PORT_RST && pull_ff == spm_pkg::PORT_RST)
        else $error("port not input after reset");
    bg_entry_c: cover property (@(posedge hclk) $rose(bgnd_ff));
    rst_fn_c: cover property (@(posedge hclk) pin_reset_req);
    force_c: cover property (@(posedge hclk) force_reset_req);
    port4_c: cover property (@(posedge hclk) released_ff && !dbg_en_ff);
endmodule

// ===== rtl/spm_pkg.sv
// Shared constants and types for the shared pin function mux
package spm_pkg;
    // Register byte offsets on the bus
    localparam logic [7:0] ADDR_OPT   = 8'h00;
    localparam logic [7:0] ADDR_FRC   = 8'h04;
    localparam logic [7:0] ADDR_STAT  = 8'h08;
    localparam logic [7:0] ADDR_DIR   = 8'h0c;
    localparam logic [7:0] ADDR_DOUT  = 8'h10;
    localparam logic [7:0] ADDR_DIN   = 8'h14;
    localparam logic [7:0] ADDR_PULL  = 8'h18;
    localparam logic [7:0] ADDR_DRV   = 8'h1c;
    localparam logic [7:0] ADDR_SLEW  = 8'h20;

    // Field positions in the option and force registers
    localparam int OPT_DBG_EN  = 0;
    localparam int OPT_RST_EN  = 1;
    localparam int OPT_IRQ_EN  = 2;
    localparam int OPT_EXTERNAL_TIMER_CLOCK_IN_EN = 3;
    localparam int FRC_BIT     = 0;

    // Port geometry
    localparam int NPINS   = 30;
    localparam int DBG_PIN = 4;
    localparam int SHR_PIN = 5;

    // Values after reset
    localparam logic [NPINS-1:0] PORT_RST = 30'h0000_0000;
    localparam logic [NPINS-1:0] SYNC_RST = 30'h3fff_ffff;
    localparam logic             DBG_EN_RST  = 1'b1;
    localparam logic             RST_EN_RST  = 1'b0;
    localparam logic             IRQ_EN_RST  = 1'b0;
    localparam logic             EXTERNAL_TIMER_CLOCK_IN_EN_RST = 1'b0;

    // Debug link timing: bus clocks per bit, debug clock at bus rate
    localparam int         BIT_CLKS   = 16;
    localparam logic [3:0] BIT_LAST   = 4'(BIT_CLKS - 1);
    // Wait count after release; ST_WAIT lasts one cycle longer than this before the mode pin is sampled
    localparam logic [1:0] SAMPLE_DLY = 2'h2;

    // Function owning the shared pin, lowest to highest priority
    typedef enum logic [1:0] {
        FN_PORT  = 2'b00,
        FN_IRQ   = 2'b01,
        FN_EXTERNAL_TIMER_CLOCK_IN  = 2'b10,
        FN_RESET = 2'b11
    } spm_func_type;

    // Mode sampling sequence after reset release
    typedef enum logic [1:0] {
        ST_WAIT   = 2'b00,
        ST_SAMPLE = 2'b01,
        ST_DONE   = 2'b10
    } spm_state_type;
endpackage

// ===== rtl/spm_sync.sv
// Two-stage synchroniser for a group of pad inputs
module spm_sync #(
    parameter int              W   = 1,
    parameter logic [W-1:0]    RST = '0
) (
    input  wire logic          clk,
    input  wire logic          rst_n,
    input  wire logic [W-1:0]  d,
    output logic      [W-1:0]  q
);
    logic [W-1:0] meta_ff;

    // First stage feeds only the second
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_ff <= RST;
            q       <= RST;
        end else begin
            meta_ff <= d;
            q       <= meta_ff;
        end
    end
endmodule
